// *** pms_defs.vh ***
// Register offsets, field positions and reset values for the SMI source logic
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
`define PMS_OFF_SP2PWR    8'h05
`define PMS_OFF_IDLE      8'h06
`define PMS_OFF_TRAPEN    8'h0c
`define PMS_OFF_STATUS    8'h14
`define PMS_RST_SP2PWR    8'h01
`define PMS_RST_IDLE      8'h1c
`define PMS_RST_TRAPEN    32'h00000000
`define PMS_RST_STATUS    32'h00000000
`define PMS_IDLE_MASK     8'h1e
`define PMS_TRAP_MASK     32'h00000aaa
`define PMS_TRAPEN_MASK   32'h0bc20aaa
`define PMS_BIT_SYSEV     17
`define PMS_BIT_SERIRQ    22
`define PMS_BIT_CTLPORT   23
`define PMS_BIT_SOFT      24
`define PMS_BIT_GLOBAL    25
`define PMS_BIT_USB       27
`define PMS_BIT_SP2PWR    0
`define PMS_SP2_FUNC_BIT  2
`define PMS_NFUNC         6
`endif

// *** pms_sticky_bit.v ***
// One sticky status flag: gated set, write-one clear, set wins
`timescale 1ns/10ps
module pms_sticky_bit (
    input  wire mclk,
    input  wire rst_n,
    input  wire setReq,
    input  wire clearReq,
    output reg  flag
);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (setReq) begin
            flag <= 1'b1;
        end else if (clearReq) begin
            flag <= 1'b0;
        end
    end
endmodule

// *** pms_trap_claim.v ***
// Claims a trapped cycle to a powered-down function: DEVSEL# then TRDY#
`timescale 1ns/10ps
module pms_trap_claim (
    input  wire mclk,
    input  wire rst_n,
    input  wire trapHit,
    output reg  devselOut,
    output reg  trdyOut
);
    reg pending;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending   <= 1'b0;
            devselOut <= 1'b0;
            trdyOut   <= 1'b0;
        end else begin
            // Claim one cycle, complete on the next
            devselOut <= trapHit | pending;
            trdyOut   <= pending;
            pending   <= trapHit;
        end
    end
endmodule

// *** pms_smi_source.v ***
// Power-management SMI source registers and SMI output
// What this block does
// - Serial port two power bit: zero low power, one normal if enabled.
// - Read-only idle status: floppy, IDE1, serial2, IDE2; reset 1Ch.
// - Enabled trap plus global enable: function access sets status bit.
// - Disabled trap leaves matching status bit unchanged on access.
// - Status 17 is combinational: enable 17 AND any system event.
// - Status 17 clears when system events or enable 17 clear; writes ignored.
// - Serial SMI with enable 22 and global enable sets status 22.
// - Control port write with enable 23 and global sets status 23.
// - Trap bits and bit 23 clear by writing one; zero ignored.
// - Software bit 24 drives the SMI output high unconditionally.
// - Global enable zero blocks setting of trap, 22, 23 bits, keeps set bits.
// - Global enable zero forces SMI low except software bit.
// - Global enable one: any status bit set raises SMI.
// - Status 27 is enable 27 AND USB controller SMI, not stored.
// - Trapped access to powered-down function claimed with DEVSEL, TRDY.
`timescale 1ns/10ps
`include "pms_defs.vh"
module pms_smi_source (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        ioWrite,
    input  wire        ioRead,
    input  wire [7:0]  ioOffset,
    input  wire [31:0] ioWdata,
    input  wire [3:0]  ioByteEn,
    output reg  [31:0] ioRdata,
    output reg         ioRvalid,
    input  wire [5:0]  funcAccess,
    input  wire [5:0]  funcPowered,
    input  wire [4:1]  idleIn,
    input  wire        sp2FuncEnable,
    input  wire        serialSmiActive,
    input  wire        controlPortWrite,
    input  wire [31:0] systemEventStatus,
    input  wire        usbSmi,
    output reg         sp2NormalPower,
    output reg         system_mgmt_irq_out,
    output wire        trapDevsel,
    output wire        trapTrdy
);
    ////////////////////////////////////////////////////////////////////
    reg  [7:0]  sp2Power;
    reg  [7:0]  idleStatus;
    reg  [31:0] trapEnable;
    reg         serSmiFlag;
    wire [5:0]  trapFlag;
    wire [31:0] status;
    wire [31:0] wmask;
    wire        globalEn;
    wire        wrEn;
    wire        wrStat;
    wire        ctlFlag;
    wire [5:0]  trapHitVec;

    assign wmask = {{8{ioByteEn[3]}}, {8{ioByteEn[2]}},
                    {8{ioByteEn[1]}}, {8{ioByteEn[0]}}};
    assign globalEn = trapEnable[`PMS_BIT_GLOBAL];
    assign wrEn   = ioWrite && (ioOffset == `PMS_OFF_TRAPEN);
    assign wrStat = ioWrite && (ioOffset == `PMS_OFF_STATUS);

    ////////////////////////////////////////////////////////////////////
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sp2Power   <= `PMS_RST_SP2PWR;
            idleStatus <= `PMS_RST_IDLE;
            trapEnable <= `PMS_RST_TRAPEN;
        end else begin
            if (ioWrite && ioOffset == `PMS_OFF_SP2PWR && ioByteEn[0])
                sp2Power <= {7'h00, ioWdata[`PMS_BIT_SP2PWR]};
            // idle status sampled, reserved bits zero
            idleStatus <= {3'h0, idleIn, 1'b0};
            if (wrEn)
                trapEnable <= (trapEnable & ~wmask) |
                              (ioWdata & wmask & `PMS_TRAPEN_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trap flags: function index i maps to status bit 2*i+1
    genvar gi;
    generate
        for (gi = 0; gi < `PMS_NFUNC; gi = gi + 1) begin : gTrap
            assign trapHitVec[gi] = funcAccess[gi] & globalEn &
                                    trapEnable[2*gi+1];
            pms_sticky_bit uTrap (
                .mclk     (mclk),
                .rst_n    (rst_n),
                .setReq   (trapHitVec[gi]),
                .clearReq (wrStat & wmask[2*gi+1] & ioWdata[2*gi+1]),
                .flag     (trapFlag[gi])
            );
        end
    endgenerate

    // control port write sets bit 23
    pms_sticky_bit uCtl (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .setReq   (controlPortWrite & globalEn &
                   trapEnable[`PMS_BIT_CTLPORT]),
        .clearReq (wrStat & wmask[`PMS_BIT_CTLPORT] &
                   ioWdata[`PMS_BIT_CTLPORT]),
        .flag     (ctlFlag)
    );

    ////////////////////////////////////////////////////////////////////
    // Serial SMI follows the serial IRQ frame, not software
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            serSmiFlag <= 1'b0;
        end else if (serialSmiActive) begin
            // set only when enabled and global enable
            if (globalEn && trapEnable[`PMS_BIT_SERIRQ])
                serSmiFlag <= 1'b1;
        end else begin
            serSmiFlag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event bit is combinational
    // clears with the event register or enable 17
    assign status = {4'h0,
                     trapEnable[`PMS_BIT_USB] & usbSmi,
                     3'h0, ctlFlag, serSmiFlag, 4'h0,
                     trapEnable[`PMS_BIT_SYSEV] & (|systemEventStatus),
                     5'h00,
                     trapFlag[5], 1'b0, trapFlag[4], 1'b0,
                     trapFlag[3], 1'b0, trapFlag[2], 1'b0,
                     trapFlag[1], 1'b0, trapFlag[0], 1'b0};

    ////////////////////////////////////////////////////////////////////
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            system_mgmt_irq_out <= 1'b0;
            sp2NormalPower      <= 1'b0;
            ioRdata             <= 32'h00000000;
            ioRvalid            <= 1'b0;
        end else begin
            system_mgmt_irq_out <= trapEnable[`PMS_BIT_SOFT] |
                                   (globalEn & (|status));
            // normal only with function enable too
            sp2NormalPower <= sp2Power[`PMS_BIT_SP2PWR] & sp2FuncEnable;
            ioRvalid <= ioRead;
            case (ioOffset)
                `PMS_OFF_SP2PWR: ioRdata <= {24'h000000, sp2Power};
                `PMS_OFF_IDLE:   ioRdata <= {24'h000000, idleStatus};
                `PMS_OFF_TRAPEN: ioRdata <= trapEnable;
                `PMS_OFF_STATUS: ioRdata <= status;
                default:         ioRdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // claim trapped cycle to powered-down function
    pms_trap_claim uClaim (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .trapHit   (|(trapHitVec & ~funcPowered)),
        .devselOut (trapDevsel),
        .trdyOut   (trapTrdy)
    );
endmodule

// *** pms_smi_source_sva.sv ***
// SMI output and trap claim assertions for the SMI source block
`timescale 1ns/10ps
module pms_smi_source_sva (
    input wire        mclk, rst_n, ioWrite, serialSmiActive,
    input wire        controlPortWrite, usbSmi, system_mgmt_irq_out,
    input wire        trapDevsel, trapTrdy,
    input wire [7:0]  ioOffset,
    input wire [31:0] ioWdata, systemEventStatus,
    input wire [5:0]  funcAccess, funcPowered
);
    reg  [31:0] en;
    wire        smi = system_mgmt_irq_out;
    wire [5:0]  hit = funcAccess & {en[11],en[9],en[7],en[5],en[3],en[1]};
    // Shadow only holds for full-word writes of defined bits
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) en <= 32'h0;
        else if (ioWrite && ioOffset == 8'h0c) en <= ioWdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_on(c); c && en[25] ##1 en[25]; endsequence
    sequence s_claim; trapDevsel ##1 trapDevsel && trapTrdy; endsequence
    property p_trap; s_on(|hit) |=> smi; endproperty
    a_trap: assert property (p_trap) else $error("trap");
    property p_port; s_on(controlPortWrite && en[23]) |=> smi; endproperty
    a_port: assert property (p_port) else $error("port");
    property p_ser; s_on(serialSmiActive && en[22]) |=> smi; endproperty
    a_ser: assert property (p_ser) else $error("serial");
    property p_sev; en[25] && en[17] && |systemEventStatus |=> smi; endproperty
    a_sev: assert property (p_sev) else $error("event");
    property p_usb; en[25] && en[27] && usbSmi |=> smi; endproperty
    a_usb: assert property (p_usb) else $error("usb");
    property p_soft; en[24] |=> smi; endproperty
    a_soft: assert property (p_soft) else $error("soft");
    property p_off; !en[25] && !en[24] |=> !smi; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_claim; en[25] && |(hit & ~funcPowered) |=> s_claim; endproperty
    a_claim: assert property (p_claim) else $error("claim");
endmodule
bind pms_smi_source pms_smi_source_sva u_sva (.*);

// *** pms_host_model.sv ***
// Host model issuing power-management I/O cycles
`timescale 1ns/10ps
module pms_host_model (
    input  wire        mclk,
    input  wire [31:0] ioRdata,
    output reg         ioWrite = 1'b0,
    output reg         ioRead = 1'b0,
    output reg  [7:0]  ioOffset = 8'h00,
    output reg  [31:0] ioWdata = 32'h0,
    output reg  [3:0]  ioByteEn = 4'h0
);
    task wr(input [7:0] o, input [31:0] v);
        @(negedge mclk);
        {ioWrite, ioOffset, ioWdata, ioByteEn} = {1'b1, o, v, 4'hf};
        @(negedge mclk);
        // Released data inverted so a stale word never looks valid
        {ioWrite, ioWdata, ioByteEn} = {1'b0, ~v, 4'h0};
    endtask
    task rd(input [7:0] o, output [31:0] v);
        @(negedge mclk);
        {ioRead, ioOffset} = {1'b1, o};
        @(negedge mclk);
        ioRead = 1'b0;
        v = ioRdata;
    endtask
endmodule

// *** pms_smi_source_tb_top.sv ***
// Self-checking bench for the SMI source block
`timescale 1ns/10ps
module pms_smi_source_tb_top;
    reg         mclk = 1'b0, rst_n = 1'b0, ser = 1'b0;
    reg         cpw = 1'b0, usb = 1'b0;
    reg  [5:0]  fa = 6'h00;
    reg  [31:0] sev = 32'h0, d;
    wire        w, r, np, smi, rv;
    wire [7:0]  o;
    wire [31:0] wd, rdat;
    wire [3:0]  be;
    integer     n_errors = 0, n_tests = 0, i;
    always #5 mclk = ~mclk;
    pms_host_model host (.mclk(mclk), .ioRdata(rdat), .ioWrite(w),
        .ioRead(r), .ioOffset(o), .ioWdata(wd), .ioByteEn(be));
    pms_smi_source dut (.mclk(mclk), .rst_n(rst_n), .ioWrite(w), .ioRead(r),
        .ioOffset(o), .ioWdata(wd), .ioByteEn(be), .ioRdata(rdat),
        .ioRvalid(rv), .funcAccess(fa), .funcPowered(6'h00), .idleIn(4'he),
        .sp2FuncEnable(1'b1), .serialSmiActive(ser), .controlPortWrite(cpw),
        .systemEventStatus(sev), .usbSmi(usb), .sp2NormalPower(np),
        .system_mgmt_irq_out(smi), .trapDevsel(), .trapTrdy());
    task chk(input [23:0] nm, input [31:0] e, input [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        host.rd(a, d);
        chk("rvl", 32'h1, {31'h0, rv});
        chk("reg", e, d);
    endtask
    task pulse(input [5:0] f, input c);
        @(negedge mclk);
        {fa, cpw} = {f, c};
        @(negedge mclk);
        {fa, cpw} = 7'h00;
    endtask
    task t_regs;
        rchk(8'h06, 32'h1c);
        rchk(8'h05, 32'h01);
        host.wr(8'h05, 32'hfe);
        rchk(8'h05, 32'h0);
        rchk(8'h20, 32'h0);
        chk("sp2", 32'h0, {31'h0, np});
    endtask
    task t_trap;
        host.wr(8'h0c, 32'h02000aaa);
        for (i = 1; i < 12; i = i + 2) begin
            pulse(6'h01 << (i / 2), 1'b0);
            host.wr(8'h14, ~(32'h1 << i));
            rchk(8'h14, 32'h1 << i);
            host.wr(8'h14, 32'h1 << i);
            rchk(8'h14, 32'h0);
        end
    endtask
    task t_glob;
        host.wr(8'h0c, 32'h00800002);
        pulse(6'h01, 1'b1);
        rchk(8'h14, 32'h0);
        host.wr(8'h0c, 32'h02800000);
        pulse(6'h3f, 1'b1);
        host.wr(8'h0c, 32'h01800000);
        rchk(8'h14, 32'h00800000);
        chk("smi", 32'h1, {31'h0, smi});
        host.wr(8'h0c, 32'h00800000);
        rchk(8'h14, 32'h00800000);
        chk("smi", 32'h0, {31'h0, smi});
    endtask
    task t_comb;
        host.wr(8'h0c, 32'h0a420000);
        {sev, usb, ser} = {32'h00010000, 2'b11};
        host.wr(8'h14, 32'h08420000);
        rchk(8'h14, 32'h08c20000);
        // Far source sends its inactive serial indication
        {sev, usb, ser} = 34'h0;
        rchk(8'h14, 32'h00800000);
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        t_regs;
        t_trap;
        t_glob;
        t_comb;
        final_report;
    end
    task final_report;
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule
